//--- lo_cal_pkg.sv
// Purpose: Constants for the LO buffer and synthesizer calibration registers
// Assumes: APB with 32-bit data; register index times four is the byte address
// Notes:   Calibration times are counted in reference periods, one per pclk
`default_nettype none
package lo_cal_pkg;

  // ----------------------------------------
  // Register indices and addresses
  // ----------------------------------------
  localparam logic [7:0] IDX_SWING  = 8'h18;
  localparam logic [7:0] IDX_BIAS   = 8'h19;
  localparam logic [7:0] IDX_BW     = 8'h1A;
  localparam logic [7:0] IDX_TUNE   = 8'h1B;
  localparam logic [7:0] IDX_SETUP  = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] SWING_RST = 8'hE1;  // 3,4,1
  localparam logic [7:0] BIAS_RST  = 8'h65;  // 1,4,5
  localparam logic [7:0] BW_RST    = 8'h86;
  localparam logic [7:0] TUNE_RST  = 8'h05;
  localparam logic [1:0] SETUP_RST = 2'h0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TUNE_START_BIT = 7;
  localparam int TUNE_DUAL_BIT  = 6;
  localparam int TUNE_WAIT_LSB  = 4;
  localparam int TUNE_RSVD_BIT  = 3;
  localparam int SETUP_BAND_BIT = 0;
  localparam int SETUP_FSEL_BIT = 1;

  // ----------------------------------------
  // Calibration durations, reference periods
  // ----------------------------------------
  localparam int unsigned CAL_T0 = 90000;
  localparam int unsigned CAL_T1 = 110000;
  localparam int unsigned CAL_T2 = 130000;
  localparam int unsigned CAL_T3 = 200000;
  localparam int CNT_W = 18;

  typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_e;

endpackage
`default_nettype wire

//--- lo_cal_regs.sv
// Purpose: LO buffer, loop bandwidth and calibration sequencer registers
// Assumes: APB slave, one wait state per access, reference clock is pclk
// Notes:   Calibration result is modelled as the latched DAC start value
//
// Functional notes
// - Rising write of start bit launches calibration; zero means inactive.
// - Dual bit clear stores in selected set; set stores in both.
// - Wait code 0..3 picks 90000, 110000, 130000, 200000 periods.
// - Prescaler swing field bits 7:6 resets to 3.
// - Receive buffer swing field bits 5:3 resets to 4.
// - Transmit buffer swing field bits 2:0 resets to 1.
// - Prescaler current field bits 7:6 resets to 1.
// - Receive buffer current field bits 5:3 resets to 4.
// - Transmit buffer current field bits 2:0 resets to 5.
// - Loop bandwidth scale resets to 134; software loads computed value.
// - Band choice bit picks low band at 0, high band at 1.
// - Tuning control low three bits hold DAC start, reset 5.
`timescale 1ns/10ps
`default_nettype none
module lo_cal_regs
  import lo_cal_pkg::*;
#(
  parameter int unsigned CAL_WAIT0 = CAL_T0,
  parameter int unsigned CAL_WAIT1 = CAL_T1,
  parameter int unsigned CAL_WAIT2 = CAL_T2,
  parameter int unsigned CAL_WAIT3 = CAL_T3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [7:0]  swing_cfg,
  output var  logic [7:0]  bias_cfg,
  output var  logic [7:0]  bw_scale,
  output var  logic        band_choice,
  output var  logic        cal_busy,
  output var  logic [2:0]  result_a,
  output var  logic [2:0]  result_b
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [7:0]  swing_r;
  logic [7:0]  bias_r;
  logic [7:0]  bw_r;
  logic [7:0]  tune_r;
  logic [1:0]  setup_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  cal_state_e  state_r;
  logic [CNT_W-1:0] cnt_r;
  logic        dual_r;
  logic        fsel_r;
  logic [2:0]  dac_r;
  logic [2:0]  res_a_r;
  logic [2:0]  res_b_r;

  wire access    = psel & penable;
  wire commit    = access & pready_r;
  wire wr        = commit & pwrite;
  wire sel_swing = paddr == byte_addr(IDX_SWING);
  wire sel_bias  = paddr == byte_addr(IDX_BIAS);
  wire sel_bw    = paddr == byte_addr(IDX_BW);
  wire sel_tune  = paddr == byte_addr(IDX_TUNE);
  wire sel_setup = paddr == byte_addr(IDX_SETUP);
  wire sel_stat  = paddr == byte_addr(IDX_STATUS);
  wire mapped    = sel_swing | sel_bias | sel_bw | sel_tune | sel_setup | sel_stat;
  // Status is read only; writes there are refused
  wire bad       = ~mapped | (pwrite & sel_stat);

  wire [7:0] stat_val = {1'b0, res_b_r, res_a_r, state_r == CAL_RUN};
  wire [7:0] rd_val =
    sel_swing ? swing_r :
    sel_bias  ? bias_r  :
    sel_bw    ? bw_r    :
    sel_tune  ? tune_r  :
    sel_setup ? {6'h00, setup_r} :
    sel_stat  ? stat_val : 8'h00;

  // ----------------------------------------
  // Calibration control
  // ----------------------------------------
  wire wr_tune  = wr & sel_tune;
  // Only a 0 to 1 step of the stored bit starts a run
  // Gated by idle so a 0, 1 rewrite mid-run cannot reload count or DAC start
  wire cal_go   = wr_tune & pwdata[TUNE_START_BIT] & ~tune_r[TUNE_START_BIT] & (state_r == CAL_IDLE);
  wire [1:0] wait_sel = pwdata[TUNE_WAIT_LSB+1:TUNE_WAIT_LSB];
  wire [CNT_W-1:0] wait_cnt =
    wait_sel == 2'h0 ? CNT_W'(CAL_WAIT0 - 1) :
    wait_sel == 2'h1 ? CNT_W'(CAL_WAIT1 - 1) :
    wait_sel == 2'h2 ? CNT_W'(CAL_WAIT2 - 1) :
                       CNT_W'(CAL_WAIT3 - 1);
  wire cal_done = (state_r == CAL_RUN) & (cnt_r == '0);
  wire store_a  = cal_done & (dual_r | ~fsel_r);
  wire store_b  = cal_done & (dual_r | fsel_r);

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // One wait state keeps read data and error straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & bad;
      if (access & ~pready_r & ~pwrite) begin
        prdata_r <= {24'h000000, rd_val};
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swing_r <= SWING_RST;
      bias_r  <= BIAS_RST;
      bw_r    <= BW_RST;
      tune_r  <= TUNE_RST;
      setup_r <= SETUP_RST;
    end else begin
      if (wr & sel_swing) begin
        swing_r <= pwdata[7:0];
      end
      if (wr & sel_bias) begin
        bias_r <= pwdata[7:0];
      end
      if (wr & sel_bw) begin
        bw_r <= pwdata[7:0];
      end
      if (wr_tune) begin
        // Reserved bit held at zero
        tune_r <= pwdata[7:0] & ~(8'h01 << TUNE_RSVD_BIT);
      end
      if (wr & sel_setup) begin
        setup_r <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Calibration sequencer
  // ----------------------------------------
  // A new start during a run is ignored; the bit must fall first anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CAL_IDLE;
      cnt_r   <= '0;
      dual_r  <= 1'b0;
      fsel_r  <= 1'b0;
      dac_r   <= 3'h0;
      res_a_r <= 3'h0;
      res_b_r <= 3'h0;
    end else begin
      unique case (state_r)
        CAL_IDLE: begin
          if (cal_go) begin
            state_r <= CAL_RUN;
            cnt_r   <= wait_cnt;
            dual_r  <= pwdata[TUNE_DUAL_BIT];
            fsel_r  <= setup_r[SETUP_FSEL_BIT];
            dac_r   <= pwdata[2:0];
          end
        end
        CAL_RUN: begin
          if (cal_done) begin
            state_r <= CAL_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
      if (store_a) begin
        res_a_r <= dac_r;
      end
      if (store_b) begin
        res_b_r <= dac_r;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign swing_cfg   = swing_r;
  assign bias_cfg    = bias_r;
  assign bw_scale    = bw_r;
  assign band_choice = setup_r[SETUP_BAND_BIT];
  assign cal_busy    = state_r == CAL_RUN;
  assign result_a    = res_a_r;
  assign result_b    = res_b_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_go;
    cal_go;
  endsequence

  sequence s_running;
    cal_busy [*2];
  endsequence

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      s_go ##1 1'b1 |-> s_running;
  endproperty
  a_start: assert property (p_start) else $error("Start did not launch calibration");

  property p_no_start;
    @(posedge pclk) disable iff (!presetn)
      !cal_busy && !cal_go |=> !cal_busy;
  endproperty
  a_no_start: assert property (p_no_start) else $error("Calibration began without start");

  property p_wait;
    @(posedge pclk) disable iff (!presetn)
      cal_go && wait_sel == 2'h0 |=> cnt_r == CNT_W'(CAL_WAIT0 - 1);
  endproperty
  a_wait: assert property (p_wait) else $error("Wait code 0 load wrong");

  property p_end;
    @(posedge pclk) disable iff (!presetn)
      $fell(cal_busy) |-> $past(cnt_r) == '0;
  endproperty
  a_end: assert property (p_end) else $error("Calibration ended early");

  property p_dual;
    @(posedge pclk) disable iff (!presetn)
      cal_done && dual_r |=> result_a == $past(dac_r) && result_b == $past(dac_r);
  endproperty
  a_dual: assert property (p_dual) else $error("Dual store missed a set");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
      cal_done && !dual_r && fsel_r |=> $stable(result_a) && result_b == $past(dac_r);
  endproperty
  a_single: assert property (p_single) else $error("Single store hit wrong set");

  property p_bw;
    @(posedge pclk) disable iff (!presetn)
      !(wr && sel_bw) |=> $stable(bw_scale);
  endproperty
  a_bw: assert property (p_bw) else $error("Bandwidth scale changed without write");

  property p_swing;
    @(posedge pclk) disable iff (!presetn)
      wr && sel_swing |=> swing_cfg == $past(pwdata[7:0]);
  endproperty
  a_swing: assert property (p_swing) else $error("Swing write lost");

  property p_bias;
    @(posedge pclk) disable iff (!presetn)
      !(wr && sel_bias) |=> $stable(bias_cfg);
  endproperty
  a_bias: assert property (p_bias) else $error("Bias changed without write");

  property p_band;
    @(posedge pclk) disable iff (!presetn)
      wr && sel_setup |=> band_choice == $past(pwdata[0]);
  endproperty
  a_band: assert property (p_band) else $error("Band choice write lost");

  property p_dac;
    @(posedge pclk) disable iff (!presetn)
      cal_go |=> dac_r == tune_r[2:0];
  endproperty
  a_dac: assert property (p_dac) else $error("DAC start not latched");

endmodule
`default_nettype wire

//--- apb_host.sv
// Purpose: APB host model issuing register transfers
// Assumes: one transfer at a time
// Notes:   Unbounded wait on pready; the bench watchdog cuts hangs
`timescale 1ns/10ps
`default_nettype none
module apb_host (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [9:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
  end

  // ------------------------------
  // Transfer
  // ------------------------------
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- lo_buffer_and_pll_calibration_regs_tb.sv
// Purpose: Self-checking bench for the LO buffer and calibration registers
// Assumes: wait counts shortened to 5, 6, 7, 8 periods
// Notes:   Random register data, seed 32
`timescale 1ns/10ps
`default_nettype none
module lo_buffer_and_pll_calibration_regs_tb;
  import lo_cal_pkg::*;
  int unsigned waits[4] = '{5, 6, 7, 8};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [7:0]  swing_cfg, bias_cfg, bw_scale;
  logic [7:0]  shadow[3];
  logic        band_choice, cal_busy, err;
  logic [2:0]  result_a, result_b, exp_a, exp_b;
  int          miscompares, samples_checked, seed;

  lo_cal_regs #(.CAL_WAIT0(5), .CAL_WAIT1(6), .CAL_WAIT2(7), .CAL_WAIT3(8)) lo_cal_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .swing_cfg(swing_cfg), .bias_cfg(bias_cfg), .bw_scale(bw_scale), .band_choice(band_choice),
    .cal_busy(cal_busy), .result_a(result_a), .result_b(result_b));
  apb_host apb_host_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    apb_host_i.xfer(1'b1, {idx, 2'b00}, v, rd, err);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb_host_i.xfer(1'b0, {idx, 2'b00}, 32'h0, rd, err);
    check(rd, exp);
  endtask
  task automatic cal(input logic [1:0] code, input logic dual, input logic fsel, input logic [2:0] dac);
    int n;
    n = 0;
    wr(IDX_SETUP, {30'h0, fsel, 1'b0});
    wr(IDX_TUNE, {24'h0, 1'b0, dual, code, 1'b0, dac});
    wr(IDX_TUNE, {24'h0, 1'b1, dual, code, 1'b0, dac});
    @(posedge pclk);
    while (cal_busy === 1'b1 && n < 300) begin
      n++;
      @(posedge pclk);
    end
    check(32'(n), 32'(waits[code]));
    if (dual || !fsel) exp_a = dac;
    if (dual || fsel) exp_b = dac;
    rdchk(IDX_STATUS, {25'h0, exp_b, exp_a, 1'b0});
    check({26'h0, result_b, result_a}, {26'h0, exp_b, exp_a});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    seed = 32;
    miscompares = 0;
    samples_checked = 0;
    exp_a = 3'h0;
    exp_b = 3'h0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_SWING, {24'h0, 2'h3, 3'h4, 3'h1});
    rdchk(IDX_BIAS, {24'h0, 2'h1, 3'h4, 3'h5});
    rdchk(IDX_BW, 32'h0000_0086);
    rdchk(IDX_TUNE, 32'h5);
    for (int i = 0; i < 9; i++) begin
      d = $random(seed);
      wr(IDX_SWING + 8'(i % 3), d);
      shadow[i % 3] = d[7:0];
      rdchk(IDX_SWING + 8'(i % 3), {24'h0, d[7:0]});
    end
    check({8'h0, swing_cfg, bias_cfg, bw_scale}, {8'h0, shadow[0], shadow[1], shadow[2]});
    wr(IDX_SETUP, 32'h1);
    // Write lands on the edge the task returns at; look once it has settled
    @(negedge pclk);
    check({31'h0, band_choice}, 32'h1);
    wr(IDX_SETUP, 32'h0);
    @(negedge pclk);
    check({31'h0, band_choice}, 32'h0);
    wr(8'h20, 32'hFF);
    check({31'h0, err}, 32'h1);
    wr(IDX_STATUS, 32'hFF);
    check({31'h0, err}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      d = $random(seed);
      cal(2'(c), c[0], c[1], d[2:0]);
    end
    // Start already stored high: no new rising edge, so no calibration
    wr(IDX_TUNE, {24'h0, 1'b1, 1'b1, 2'h3, 1'b1, 3'h2});
    @(posedge pclk);
    check({31'h0, cal_busy}, 32'h0);
    rdchk(IDX_TUNE, {24'h0, 1'b1, 1'b1, 2'h3, 1'b0, 3'h2});
    finish_test();
  end

  initial begin
    #(25 * 5000);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
